// ===== shared/simask_params.svh
// Constants of the stage interrupt enable mask block.
// Functional notes
// - Enabled upper-threshold stage 0..11 exceeding its limit asserts the interrupt.
// - A stage whose enable bit is 0 never causes the interrupt.
// - Upper-threshold mask at index 0x006, read/write, bits 0..11, reset 0.
// - Enabled conversion-done stage asserts the interrupt once its conversion finishes.
// - Conversion-done mask at index 0x007, read/write, bit n per stage, reset 0.
// - Threshold status clears after readback unless the limit is still exceeded.
`ifndef SIMASK_PARAMS_SVH
`define SIMASK_PARAMS_SVH

`define SIMASK_UPPER_STAGES   12
`define SIMASK_DONE_STAGES    7
`define SIMASK_ADDR_W         12
`define SIMASK_DATA_W         32

`define SIMASK_IDX_UPPER_MASK 12'h006
`define SIMASK_IDX_DONE_MASK  12'h007
`define SIMASK_IDX_UPPER_STAT 12'h009
`define SIMASK_IDX_DONE_STAT  12'h00a
`define SIMASK_BYTE_ADDR(i)   ((i) << 2)

`define SIMASK_UPPER_RST      12'h000
`define SIMASK_DONE_RST       7'h00
`define SIMASK_DATA_ZERO      32'h0000_0000

`endif

// ===== shared/simask_pkg.sv
// Types shared by the stage interrupt enable mask block.
`default_nettype none
`include "simask_params.svh"
package simask_pkg;

  typedef enum logic [1:0] {
    SIMASK_BUS_IDLE = 2'b01,
    SIMASK_BUS_RESP = 2'b10
  } simask_bus_t;

  typedef enum logic [4:0] {
    SIMASK_SEL_NONE       = 5'b00001,
    SIMASK_SEL_UPPER_MASK = 5'b00010,
    SIMASK_SEL_DONE_MASK  = 5'b00100,
    SIMASK_SEL_UPPER_STAT = 5'b01000,
    SIMASK_SEL_DONE_STAT  = 5'b10000
  } simask_sel_t;

  typedef struct packed {
    simask_bus_t                       bus;
    simask_sel_t                       sel;
    logic [`SIMASK_UPPER_STAGES-1:0]   upper_mask;
    logic [`SIMASK_DONE_STAGES-1:0]    done_mask;
    logic [`SIMASK_UPPER_STAGES-1:0]   upper_stat;
    logic [`SIMASK_DONE_STAGES-1:0]    done_stat;
    logic [`SIMASK_DATA_W-1:0]         prdata;
    logic                              pready;
    logic                              pslverr;
    logic                              irq_n;
  } simask_state_t;

endpackage : simask_pkg
`default_nettype wire

// ===== src/simask_top.sv
// APB-mapped per-stage interrupt enable masks with sticky event status and interrupt.
//
// The APB register port was decided locally.
`default_nettype none
`include "simask_params.svh"
module simask_top
  import simask_pkg::*;
(
  input  wire logic                            clk_in,
  input  wire logic                            rst_in,
  input  wire logic                            psel_in,
  input  wire logic                            penable_in,
  input  wire logic                            pwrite_in,
  input  wire logic [`SIMASK_ADDR_W-1:0]       paddr_in,
  input  wire logic [`SIMASK_DATA_W-1:0]       pwdata_in,
  input  wire logic [`SIMASK_UPPER_STAGES-1:0] upper_exceed_in,
  input  wire logic [`SIMASK_DONE_STAGES-1:0]  conv_done_in,
  output var  logic [`SIMASK_DATA_W-1:0]       prdata_out,
  output var  logic                            pready_out,
  output var  logic                            pslverr_out,
  output var  logic                            irq_n_out
);

  simask_state_t s_q;
  simask_state_t s_d;

  function automatic simask_sel_t decode(input logic [`SIMASK_ADDR_W-1:0] a);
    simask_sel_t r;
    r = SIMASK_SEL_NONE;
    if (a == `SIMASK_BYTE_ADDR(`SIMASK_IDX_UPPER_MASK)) begin
      r = SIMASK_SEL_UPPER_MASK;
    end else if (a == `SIMASK_BYTE_ADDR(`SIMASK_IDX_DONE_MASK)) begin
      r = SIMASK_SEL_DONE_MASK;
    end else if (a == `SIMASK_BYTE_ADDR(`SIMASK_IDX_UPPER_STAT)) begin
      r = SIMASK_SEL_UPPER_STAT;
    end else if (a == `SIMASK_BYTE_ADDR(`SIMASK_IDX_DONE_STAT)) begin
      r = SIMASK_SEL_DONE_STAT;
    end
    return r;
  endfunction : decode

  function automatic logic [`SIMASK_DATA_W-1:0] read_value(input simask_sel_t  sel,
                                                           input simask_state_t s);
    logic [`SIMASK_DATA_W-1:0] v;
    v = `SIMASK_DATA_ZERO;
    case (sel)
      SIMASK_SEL_UPPER_MASK: v[`SIMASK_UPPER_STAGES-1:0] = s.upper_mask;
      SIMASK_SEL_DONE_MASK:  v[`SIMASK_DONE_STAGES-1:0]  = s.done_mask;
      SIMASK_SEL_UPPER_STAT: v[`SIMASK_UPPER_STAGES-1:0] = s.upper_stat;
      SIMASK_SEL_DONE_STAT:  v[`SIMASK_DONE_STAGES-1:0]  = s.done_stat;
      default:               v = `SIMASK_DATA_ZERO;
    endcase
    return v;
  endfunction : read_value

  logic                            req_access;
  logic                            req_commit;
  logic [`SIMASK_UPPER_STAGES-1:0] upper_pend;
  logic [`SIMASK_DONE_STAGES-1:0]  done_pend;

  always_comb begin
    s_d        = s_q;
    req_access = psel_in && penable_in;
    req_commit = req_access && s_q.pready;

    // Set wins over clear: only bits that were actually returned are cleared,
    // and a limit still exceeded or a fresh completion re-sets its bit at once.
    s_d.upper_stat = s_q.upper_stat | upper_exceed_in;
    s_d.done_stat  = s_q.done_stat | conv_done_in;

    case (s_q.bus)
      SIMASK_BUS_IDLE: begin
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        if (req_access) begin
          // The answer is prepared one cycle ahead so every bus output is a flop.
          s_d.sel     = decode(paddr_in);
          s_d.prdata  = pwrite_in ? `SIMASK_DATA_ZERO : read_value(decode(paddr_in), s_q);
          s_d.pslverr = (decode(paddr_in) == SIMASK_SEL_NONE);
          s_d.pready  = 1'b1;
          s_d.bus     = SIMASK_BUS_RESP;
        end
      end
      SIMASK_BUS_RESP: begin
        if (req_commit) begin
          if (pwrite_in) begin
            if (s_q.sel == SIMASK_SEL_UPPER_MASK) begin
              // Bits 15..12 are expected zero from software and are not stored.
              s_d.upper_mask = pwdata_in[`SIMASK_UPPER_STAGES-1:0];
            end
            if (s_q.sel == SIMASK_SEL_DONE_MASK) begin
              s_d.done_mask = pwdata_in[`SIMASK_DONE_STAGES-1:0];
            end
          end else begin
            if (s_q.sel == SIMASK_SEL_UPPER_STAT) begin
              s_d.upper_stat = (s_q.upper_stat & ~s_q.prdata[`SIMASK_UPPER_STAGES-1:0])
                               | upper_exceed_in;
            end
            if (s_q.sel == SIMASK_SEL_DONE_STAT) begin
              s_d.done_stat = (s_q.done_stat & ~s_q.prdata[`SIMASK_DONE_STAGES-1:0])
                              | conv_done_in;
            end
          end
        end
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.prdata  = `SIMASK_DATA_ZERO;
        s_d.sel     = SIMASK_SEL_NONE;
        s_d.bus     = SIMASK_BUS_IDLE;
      end
      default: begin
        s_d.bus = SIMASK_BUS_IDLE;
      end
    endcase

    upper_pend = s_d.upper_stat & s_d.upper_mask;
    done_pend  = s_d.done_stat & s_d.done_mask;
    s_d.irq_n  = ~(|upper_pend || |done_pend);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q.bus        <= SIMASK_BUS_IDLE;
      s_q.sel        <= SIMASK_SEL_NONE;
      s_q.upper_mask <= `SIMASK_UPPER_RST;
      s_q.done_mask  <= `SIMASK_DONE_RST;
      s_q.upper_stat <= `SIMASK_UPPER_RST;
      s_q.done_stat  <= `SIMASK_DONE_RST;
      s_q.prdata     <= `SIMASK_DATA_ZERO;
      s_q.pready     <= 1'b0;
      s_q.pslverr    <= 1'b0;
      s_q.irq_n      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_out  = s_q.prdata;
  assign pready_out  = s_q.pready;
  assign pslverr_out = s_q.pslverr;
  assign irq_n_out   = s_q.irq_n;

endmodule : simask_top
`default_nettype wire

// ===== test/simask_checker.sv
// Port checker for the stage interrupt mask block.
`default_nettype none
`include "simask_params.svh"
module simask_checker (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [11:0] upper_exceed_in,
  input wire logic [6:0]  conv_done_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        irq_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence first_acc;
    psel_in && $rose(penable_in);
  endsequence
  chk_ready_wait: assert property (first_acc |=> pready_out) else $error("late ready");
  chk_ready_pulse: assert property (pready_out |=> !pready_out) else $error("long ready");
  chk_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("stray ready");
  chk_err_addr: assert property (pready_out |-> pslverr_out == $past(!(paddr_in inside
    {12'h018, 12'h01c, 12'h024, 12'h028}))) else $error("bad decode");
  chk_data_idle: assert property (!pready_out |-> prdata_out == 32'h0) else $error("data");
  chk_read_width: assert property (pready_out |-> prdata_out[31:12] == 20'h0)
    else $error("high bits");
  chk_irq_fall: assert property ($fell(irq_n_out) |-> $past(|{upper_exceed_in, conv_done_in}
    || (psel_in && penable_in && pready_out && pwrite_in))) else $error("irq fall");
  chk_irq_rise: assert property ($rose(irq_n_out) |-> $past(psel_in && penable_in && pready_out))
    else $error("irq rise");
endmodule : simask_checker
bind simask_top simask_checker u_chk (.*);
`default_nettype wire

// ===== test/simask_host.sv
// Host model that counts the interrupt requests it sees, one per falling edge of irq_n_in.
`default_nettype none
module simask_host (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       irq_n_in,
  output var logic [7:0] hits_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_q;
  always_ff @(posedge clk_in) begin
    irq_q <= rst_in | irq_n_in;
    hits_out <= rst_in ? 8'h0 : hits_out + {7'h0, irq_q & !irq_n_in};
  end
endmodule : simask_host
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the stage interrupt mask block.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr, er, irqn;
  logic [11:0] paddr = 12'h0, upx = 12'h0;
  logic [6:0] cdone = 7'h0;
  logic [7:0] hits;
  logic [31:0] pwd = 32'h0, prd, rd;
  int bad_count = 0, total_checks = 0, cyc = 0;
  always #4 clk_in = ~clk_in;
  simask_top DUT (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .upper_exceed_in(upx),
    .conv_done_in(cdone), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .irq_n_out(irqn));
  simask_host host (.clk_in(clk_in), .rst_in(rst_in), .irq_n_in(irqn), .hits_out(hits));
  task cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in) {psel, pwr, paddr, pwd} <= {1'b1, w, a, d};
    @(posedge clk_in) pen <= 1'b1;
    // Reading right after the edge sees the values that stood before it, so the
    // answer is taken at the very edge at which pready is sampled high.
    do @(posedge clk_in); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    {psel, pen} <= 2'b00;
  endtask : apb
  task t_regs();
    apb(1'b0, 12'h018, 32'h0); cmp(rd, 32'h0);
    apb(1'b0, 12'h01c, 32'h0); cmp(rd, 32'h0);
    apb(1'b1, 12'h018, 32'hfff); apb(1'b0, 12'h018, 32'h0); cmp(rd, 32'hfff);
    apb(1'b1, 12'h01c, 32'h7f); apb(1'b0, 12'h01c, 32'h0); cmp(rd, 32'h7f);
    apb(1'b0, 12'h019, 32'h0); cmp({rd[30:0], er}, 32'h1);
  endtask : t_regs
  task t_stage(input logic up, input int i);
    logic [11:0] b;
    b = 12'h1 << i;
    apb(1'b1, up ? 12'h018 : 12'h01c, {20'h0, b});
    @(posedge clk_in) {upx, cdone} <= up ? {b, 7'h0} : {12'h0, b[6:0]};
    @(posedge clk_in) {upx, cdone} <= 19'h0;
    @(negedge clk_in) cmp({31'h0, irqn}, 32'h0);
    apb(1'b0, up ? 12'h024 : 12'h028, 32'h0); cmp(rd, {20'h0, b});
    @(negedge clk_in) cmp({31'h0, irqn}, 32'h1);
  endtask : t_stage
  task t_held();
    apb(1'b1, 12'h018, 32'h1);
    @(posedge clk_in) upx <= 12'h001;
    // A limit still exceeded at readback keeps its bit, and so the interrupt.
    apb(1'b0, 12'h024, 32'h0); cmp(rd, 32'h1);
    @(negedge clk_in) cmp({31'h0, irqn}, 32'h0);
    @(posedge clk_in) upx <= 12'h000;
    apb(1'b0, 12'h024, 32'h0); cmp(rd, 32'h1);
    @(negedge clk_in) cmp({31'h0, irqn}, 32'h1);
  endtask : t_held
  task t_masked();
    apb(1'b1, 12'h018, 32'h0);
    apb(1'b1, 12'h01c, 32'h0);
    @(posedge clk_in) {upx, cdone} <= 19'h7ffff;
    @(posedge clk_in) {upx, cdone} <= 19'h0;
    repeat (3) @(negedge clk_in) cmp({31'h0, irqn}, 32'h1);
    apb(1'b0, 12'h024, 32'h0); cmp(rd, 32'hfff);
    apb(1'b0, 12'h028, 32'h0); cmp(rd, 32'h7f);
  endtask : t_masked
  task stop_test();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    for (int i = 0; i < 12; i++) t_stage(1'b1, i);
    for (int i = 0; i < 7; i++) t_stage(1'b0, i);
    t_held();
    t_masked();
    cmp({24'h0, hits}, 32'h14);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
